// *** sim/cdm_debug_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cdm_cfg.svh"

// ==========================================================================
// bench for the debug mode control
module cdm_debug_ctrl_tb;
  import cdm_pkg::*;
  localparam logic [31:0] VIS = `CDM_DBG_FLAG_MASK | 32'h4000_0000;
  logic sys_clk, rst, instr_retire, sw_bp_exec, dbg_return_exec, fetch_valid;
  logic data_valid, data_write, blk_irq_req, nb_irq_req, dbg_wr_en, brk_cmd, pen_cmd;
  logic host_break_request, probe_enabled, in_debug_r, fetch_redirect_r;
  logic probe_break_taken_r, fetch_to_probe_r, data_to_probe_r;
  logic blk_irq_take_r, nb_irq_take_r;
  logic [1:0] ibp_en, dbp_en;
  logic [31:0] processor_status_word, dbg_wdata, dcs_rdata_r, dbg_rdata_r;
  cdm_addr_t fetch_addr, data_addr, fetch_redirect_pc_r;
  cdm_addr_t [1:0] ibp_addr, dbp_addr;
  int fails, comparisons;

  cdm_debug_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .instr_retire(instr_retire),
    .sw_bp_exec(sw_bp_exec), .dbg_return_exec(dbg_return_exec),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .data_valid(data_valid),
    .data_write(data_write), .data_addr(data_addr), .ibp_en(ibp_en),
    .ibp_addr(ibp_addr), .dbp_en(dbp_en), .dbp_addr(dbp_addr),
    .host_break_request(host_break_request), .probe_enabled(probe_enabled),
    .processor_status_word(processor_status_word), .blk_irq_req(blk_irq_req),
    .nb_irq_req(nb_irq_req), .dbg_wr_en(dbg_wr_en), .dbg_wdata(dbg_wdata),
    .in_debug_r(in_debug_r), .fetch_redirect_r(fetch_redirect_r),
    .fetch_redirect_pc_r(fetch_redirect_pc_r), .probe_break_taken_r(probe_break_taken_r),
    .fetch_to_probe_r(fetch_to_probe_r), .data_to_probe_r(data_to_probe_r),
    .blk_irq_take_r(blk_irq_take_r), .nb_irq_take_r(nb_irq_take_r),
    .dcs_rdata_r(dcs_rdata_r), .dbg_rdata_r(dbg_rdata_r));

  cdm_host_model u_host (.sys_clk(sys_clk), .rst(rst), .brk_cmd(brk_cmd),
    .pen_cmd(pen_cmd), .in_debug_r(in_debug_r),
    .host_break_request(host_break_request), .probe_enabled(probe_enabled));

  // ==========================================================================
  // clock, 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // called at the edge that sampled the cause
  task automatic expect_entry(input logic [31:0] flags);
    #1;
    chk(in_debug_r, 1'b1);
    chk(fetch_redirect_r, 1'b1);
    chk(fetch_redirect_pc_r, 24'hF00200);
    @(posedge sys_clk);
    #1;
    chk(fetch_redirect_r, 1'b0);
    chk(dbg_rdata_r & VIS, flags | 32'h4000_0000);
  endtask

  task automatic leave_debug();
    @(posedge sys_clk);
    dbg_return_exec <= 1'b1;
    @(posedge sys_clk);
    dbg_return_exec <= 1'b0;
    #1;
    chk(in_debug_r, 1'b0);
    @(posedge sys_clk);
    #1;
    chk(dbg_rdata_r & VIS, 32'h0);
  endtask

  task automatic report_and_stop();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      processor_status_word <= {25'h0, i[1], i[0], 5'h1F};
      nb_irq_req <= i[0] ^ i[1];
      blk_irq_req <= 1'b1;
      pen_cmd <= i[1];
      repeat (3) @(posedge sys_clk);
      #1;
      chk(dcs_rdata_r, 32'h2003_0000 | {i[0], i[1], i[0] ^ i[1], 1'b0, i[1]});
      chk(dcs_rdata_r[2], i[0] ^ i[1]);
      chk(dcs_rdata_r[0], i[1]);
      chk(blk_irq_take_r, i[0]);
      chk(nb_irq_take_r, i[1] & ~i[0]);
    end
    @(posedge sys_clk);
    {nb_irq_req, blk_irq_req, pen_cmd} <= 3'b000;
    $display("test status done");
  endtask

  task automatic t_swbp_masking();
    @(posedge sys_clk);
    sw_bp_exec <= 1'b1;
    @(posedge sys_clk);
    sw_bp_exec <= 1'b0;
    expect_entry(32'h2);
    @(posedge sys_clk);
    {sw_bp_exec, instr_retire, blk_irq_req, nb_irq_req} <= 4'hF;
    processor_status_word <= 32'h0000_0060;
    fetch_valid <= 1'b1;
    fetch_addr <= ibp_addr[0];
    @(posedge sys_clk);
    {sw_bp_exec, instr_retire, fetch_valid} <= 3'b000;
    #1;
    chk(fetch_redirect_r, 1'b0);
    @(posedge sys_clk);
    #1;
    chk({blk_irq_take_r, nb_irq_take_r, in_debug_r}, 3'b001);
    chk(dbg_rdata_r & VIS, 32'h4000_0002);
    @(posedge sys_clk);
    {blk_irq_req, nb_irq_req} <= 2'b00;
    leave_debug();
    $display("test software break done");
  endtask

  task automatic t_single_step();
    @(posedge sys_clk);
    dbg_wr_en <= 1'b1;
    dbg_wdata <= 32'h0000_0100;
    @(posedge sys_clk);
    dbg_wr_en <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(dbg_rdata_r[8], 1'b1);
    @(posedge sys_clk);
    instr_retire <= 1'b1;
    @(posedge sys_clk);
    expect_entry(32'h1);
    @(posedge sys_clk);
    instr_retire <= 1'b0;
    #1;
    chk(fetch_redirect_r, 1'b0);
    @(posedge sys_clk);
    dbg_wr_en <= 1'b1;
    dbg_wdata <= 32'h0;
    @(posedge sys_clk);
    dbg_wr_en <= 1'b0;
    leave_debug();
    $display("test single step done");
  endtask

  task automatic t_breakpoints();
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      fetch_valid <= ~i[1];
      fetch_addr <= ibp_addr[i[0]];
      data_valid <= i[1];
      data_write <= i[0];
      data_addr <= dbp_addr[i[0]];
      @(posedge sys_clk);
      {fetch_valid, data_valid} <= 2'b00;
      expect_entry(i[1] ? (32'h4_0000 << i[0]) : 32'h10);
      leave_debug();
    end
    @(posedge sys_clk);
    fetch_valid <= 1'b1;
    fetch_addr <= 24'h001004;
    @(posedge sys_clk);
    fetch_valid <= 1'b0;
    #1;
    chk(in_debug_r, 1'b0);
    $display("test breakpoints done");
  endtask

  task automatic t_probe_and_both();
    int n;
    @(posedge sys_clk);
    brk_cmd <= 1'b1;
    @(posedge sys_clk);
    brk_cmd <= 1'b0;
    for (n = 0; n < 8 && in_debug_r !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n == 8) begin
      fails++;
      report_and_stop();
    end
    chk({probe_break_taken_r, fetch_redirect_r}, 2'b11);
    leave_debug();
    #1;
    chk(in_debug_r, 1'b0);
    @(posedge sys_clk);
    sw_bp_exec <= 1'b1;
    fetch_valid <= 1'b1;
    fetch_addr <= ibp_addr[1];
    @(posedge sys_clk);
    {sw_bp_exec, fetch_valid} <= 2'b00;
    expect_entry(32'h12);
    leave_debug();
    $display("test probe and joint causes done");
  endtask

  task automatic t_routing();
    cdm_addr_t a [3] = '{24'hEFFFFF, 24'hF00000, 24'hFFFFFF};
    @(posedge sys_clk);
    ibp_en <= 2'b00;
    dbp_en <= 2'b00;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      {fetch_valid, data_valid} <= 2'b11;
      fetch_addr <= a[i];
      data_addr <= a[i];
      @(posedge sys_clk);
      {fetch_valid, data_valid} <= 2'b00;
      #1;
      chk({fetch_to_probe_r, data_to_probe_r}, {2{i != 0}});
    end
    $display("test routing done");
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    fails = 0;
    comparisons = 0;
    rst = 1'b1;
    {instr_retire, sw_bp_exec, dbg_return_exec, fetch_valid, data_valid} = 5'h00;
    {data_write, blk_irq_req, nb_irq_req, dbg_wr_en, brk_cmd, pen_cmd} = 6'h00;
    fetch_addr = 24'h0;
    data_addr = 24'h0;
    ibp_en = 2'b11;
    dbp_en = 2'b11;
    ibp_addr = {24'h002000, 24'h001000};
    dbp_addr = {24'h00A010, 24'h008000};
    processor_status_word = 32'h0;
    dbg_wdata = 32'h0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({in_debug_r, fetch_redirect_r, blk_irq_take_r}, 3'b000);
    t_status();
    t_swbp_masking();
    t_single_step();
    t_breakpoints();
    t_probe_and_both();
    t_routing();
    report_and_stop();
  end
endmodule

`default_nettype wire

// *** sim/cdm_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// host debugger behind the probe port
module cdm_host_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // commands from the bench
  input  wire logic brk_cmd,
  input  wire logic pen_cmd,
  // view of the cpu
  input  wire logic in_debug_r,
  // probe control register bits
  output var  logic host_break_request,
  output var  logic probe_enabled
);
  // the break request is a level; it is dropped once debug mode shows,
  // otherwise the return would be followed at once by a second entry
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_break_request <= 1'b0;
      probe_enabled      <= 1'b0;
    end else begin
      probe_enabled <= pen_cmd;
      if (brk_cmd) begin
        host_break_request <= 1'b1;
      end else if (in_debug_r) begin
        host_break_request <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// *** src/cdm_bp_match.sv ***
`timescale 1ns/1ps
`default_nettype none

// compares one access stream against N programmable breakpoint addresses
module cdm_bp_match #(
  parameter int N = 2
) (
  // access stream
  cdm_bus_if.matcher                    bus,
  // breakpoint conditions
  input  wire logic [N-1:0]             bp_en,
  input  wire cdm_pkg::cdm_addr_t [N-1:0] bp_addr
);
  import cdm_pkg::*;

  // refused at elaboration, the match vector is kept small on purpose
  if (N < 1 || N > 8) begin : g_bad_n
    $error("cdm_bp_match: N out of range");
  end

  // ===========================================================================
  // any enabled condition equal to the access address hits
  logic [N-1:0] eq;
  for (genvar i = 0; i < N; i++) begin : g_cmp
    assign eq[i] = bp_en[i] && (bp_addr[i] == bus.addr);
  end
  assign bus.hit = bus.valid && (|eq);
endmodule

`default_nettype wire

// *** src/cdm_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// one address stream (fetch or data) with its breakpoint hit
interface cdm_bus_if;
  import cdm_pkg::*;
  logic      valid;
  cdm_addr_t addr;
  logic      hit;
  modport source  (output valid, output addr, input hit);
  modport matcher (input valid, input addr, output hit);
  modport router  (input valid, input addr);
endinterface

`default_nettype wire

// *** src/cdm_cfg.svh ***
`ifndef CDM_CFG_SVH
`define CDM_CFG_SVH

// ===========================================================================
// address map of the debug path
`define CDM_AW              24
`define CDM_DBG_ENTRY_PC    24'hF00200
`define CDM_DSEG_LO         24'hF00000
`define CDM_DSEG_HI         24'hFFFFFF

// ===========================================================================
// debug control status register fields
`define CDM_DCS_ENDIAN      29
`define CDM_DCS_DBRK_CAP    17
`define CDM_DCS_IBRK_CAP    16
`define CDM_DCS_BLK_EN      4
`define CDM_DCS_NB_EN       3
`define CDM_DCS_NB_PEND     2
`define CDM_DCS_PROBE_EN    0
`define CDM_DCS_RSVD_MASK   32'hDFFC_FFE2

// ===========================================================================
// processor status word mask bits
`define CDM_STAT_BLK_EN     5
`define CDM_STAT_NB_EN      6

// ===========================================================================
// debug register fields
`define CDM_DBG_IN_DEBUG    30
`define CDM_DBG_COUNTDM     25
`define CDM_DBG_DSTORE      19
`define CDM_DBG_DLOAD       18
`define CDM_DBG_STEP_EN     8
`define CDM_DBG_IBRK        4
`define CDM_DBG_SWBP        1
`define CDM_DBG_SSTEP       0
`define CDM_DBG_WR_MASK     32'h0200_0100
`define CDM_DBG_FLAG_MASK   32'h000C_0013

`endif

// *** src/cdm_debug_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cdm_cfg.svh"

module cdm_debug_ctrl #(
  parameter int N_IBP = 2,
  parameter int N_DBP = 2
) (
  // clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           rst,
  // instruction stream from the pipeline
  input  wire logic                           instr_retire,
  input  wire logic                           sw_bp_exec,
  input  wire logic                           dbg_return_exec,
  input  wire logic                           fetch_valid,
  input  wire cdm_pkg::cdm_addr_t             fetch_addr,
  // data stream from the pipeline
  input  wire logic                           data_valid,
  input  wire logic                           data_write,
  input  wire cdm_pkg::cdm_addr_t             data_addr,
  // breakpoint conditions
  input  wire logic [N_IBP-1:0]               ibp_en,
  input  wire cdm_pkg::cdm_addr_t [N_IBP-1:0] ibp_addr,
  input  wire logic [N_DBP-1:0]               dbp_en,
  input  wire cdm_pkg::cdm_addr_t [N_DBP-1:0] dbp_addr,
  // probe control register bits
  input  wire logic                           host_break_request,
  input  wire logic                           probe_enabled,
  // interrupt state
  input  wire logic [31:0]                    processor_status_word,
  input  wire logic                           blk_irq_req,
  input  wire logic                           nb_irq_req,
  // debug register write port
  input  wire logic                           dbg_wr_en,
  input  wire logic [31:0]                    dbg_wdata,
  // mode and fetch redirection
  output var  logic                           in_debug_r,
  output var  logic                           fetch_redirect_r,
  output var  cdm_pkg::cdm_addr_t             fetch_redirect_pc_r,
  output var  logic                           probe_break_taken_r,
  // probe port routing
  output var  logic                           fetch_to_probe_r,
  output var  logic                           data_to_probe_r,
  // gated interrupt requests
  output var  logic                           blk_irq_take_r,
  output var  logic                           nb_irq_take_r,
  // register read data
  output var  logic [31:0]                    dcs_rdata_r,
  output var  logic [31:0]                    dbg_rdata_r
);
  import cdm_pkg::*;

  // refused at elaboration; each matcher serves one to eight conditions
  if (N_IBP < 1 || N_IBP > 8) begin : g_bad_ibp
    $error("cdm_debug_ctrl: N_IBP out of range");
  end
  if (N_DBP < 1 || N_DBP > 8) begin : g_bad_dbp
    $error("cdm_debug_ctrl: N_DBP out of range");
  end

  // ===========================================================================
  // access streams and their breakpoint matchers
  cdm_bus_if fetch_bus ();
  cdm_bus_if data_bus ();

  assign fetch_bus.valid = fetch_valid;
  assign fetch_bus.addr  = fetch_addr;
  assign data_bus.valid  = data_valid;
  assign data_bus.addr   = data_addr;

  cdm_bp_match #(.N(N_IBP)) u_ibp (
    .bus     (fetch_bus.matcher),
    .bp_en   (ibp_en),
    .bp_addr (ibp_addr)
  );

  cdm_bp_match #(.N(N_DBP)) u_dbp (
    .bus     (data_bus.matcher),
    .bp_en   (dbp_en),
    .bp_addr (dbp_addr)
  );

  // ===========================================================================
  // probe segment routing
  cdm_seg_route u_fetch_route (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .bus        (fetch_bus.router),
    .to_probe_r (fetch_to_probe_r)
  );

  cdm_seg_route u_data_route (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .bus        (data_bus.router),
    .to_probe_r (data_to_probe_r)
  );

  // ===========================================================================
  // mode state and debug register bits
  cdm_mode_t mode_r;
  cdm_mode_t mode_nxt;
  logic      step_en_r;
  logic      countdm_r;
  logic      f_sstep_r;
  logic      f_swbp_r;
  logic      f_ibrk_r;
  logic      f_dload_r;
  logic      f_dstore_r;
  logic      f_probe_r;

  // ===========================================================================
  // exception sources, all blocked while in debug mode
  wire normal_mode = (mode_r == CDM_NORMAL);
  wire src_swbp    = normal_mode && sw_bp_exec;
  wire src_sstep   = normal_mode && step_en_r && instr_retire;
  wire src_ibrk    = normal_mode && fetch_bus.hit;
  wire src_dload   = normal_mode && data_bus.hit && !data_write;
  wire src_dstore  = normal_mode && data_bus.hit && data_write;
  wire src_probe   = normal_mode && host_break_request;
  // one entry however many sources fire together
  wire take_exc    = src_swbp || src_sstep || src_ibrk ||
                     src_dload || src_dstore || src_probe;
  wire leave_dbg   = (mode_r == CDM_DEBUG) && dbg_return_exec;

  // ===========================================================================
  // mode transitions
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      CDM_NORMAL: begin
        if (take_exc) mode_nxt = CDM_DEBUG;
      end
      CDM_DEBUG: begin
        if (leave_dbg) mode_nxt = CDM_NORMAL;
      end
      default: mode_nxt = CDM_NORMAL;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) mode_r <= CDM_NORMAL;
    else     mode_r <= mode_nxt;
  end

  // ===========================================================================
  // fetch redirection to the probe-served entry point
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fetch_redirect_r    <= 1'b0;
      fetch_redirect_pc_r <= '0;
    end else begin
      fetch_redirect_r    <= normal_mode && take_exc;
      fetch_redirect_pc_r <= `CDM_DBG_ENTRY_PC;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) in_debug_r <= 1'b0;
    else     in_debug_r <= (mode_nxt == CDM_DEBUG);
  end

  // ===========================================================================
  // per-cause flags; exit cannot collide with a set since sources are blocked
  // in debug mode, so a plain clear on exit loses no event
  always_ff @(posedge sys_clk) begin
    if (rst || leave_dbg) begin
      f_sstep_r  <= 1'b0;
      f_swbp_r   <= 1'b0;
      f_ibrk_r   <= 1'b0;
      f_dload_r  <= 1'b0;
      f_dstore_r <= 1'b0;
      f_probe_r  <= 1'b0;
    end else begin
      f_sstep_r  <= f_sstep_r  || src_sstep;
      f_swbp_r   <= f_swbp_r   || src_swbp;
      f_ibrk_r   <= f_ibrk_r   || src_ibrk;
      f_dload_r  <= f_dload_r  || src_dload;
      f_dstore_r <= f_dstore_r || src_dstore;
      f_probe_r  <= f_probe_r  || src_probe;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) probe_break_taken_r <= 1'b0;
    else     probe_break_taken_r <= src_probe;
  end

  // ===========================================================================
  // writable debug register bits: single step enable and timer run in debug
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      step_en_r <= 1'b0;
      countdm_r <= 1'b0;
    end else if (dbg_wr_en) begin
      step_en_r <= dbg_wdata[`CDM_DBG_STEP_EN];
      countdm_r <= dbg_wdata[`CDM_DBG_COUNTDM];
    end
  end

  // ===========================================================================
  // interrupt gating; debug mode wins over both enable bits
  wire blk_take_nxt = blk_irq_req && processor_status_word[`CDM_STAT_BLK_EN] &&
                      normal_mode;
  wire nb_take_nxt  = nb_irq_req && processor_status_word[`CDM_STAT_NB_EN] &&
                      normal_mode;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      blk_irq_take_r <= 1'b0;
      nb_irq_take_r  <= 1'b0;
    end else begin
      blk_irq_take_r <= blk_take_nxt;
      nb_irq_take_r  <= nb_take_nxt;
    end
  end

  // ===========================================================================
  // read views; status register has no write path, so reserved bits stay zero
  logic [31:0] dcs_nxt;
  logic [31:0] dbg_nxt;

  always_comb begin
    dcs_nxt                     = 32'h0000_0000;
    dcs_nxt[`CDM_DCS_ENDIAN]    = 1'b1;
    dcs_nxt[`CDM_DCS_DBRK_CAP]  = 1'b1;
    dcs_nxt[`CDM_DCS_IBRK_CAP]  = 1'b1;
    dcs_nxt[`CDM_DCS_BLK_EN]    = processor_status_word[`CDM_STAT_BLK_EN];
    dcs_nxt[`CDM_DCS_NB_EN]     = processor_status_word[`CDM_STAT_NB_EN];
    dcs_nxt[`CDM_DCS_NB_PEND]   = nb_irq_req;
    dcs_nxt[`CDM_DCS_PROBE_EN]  = probe_enabled;
  end

  always_comb begin
    dbg_nxt                     = 32'h0000_0000;
    dbg_nxt[`CDM_DBG_IN_DEBUG]  = (mode_r == CDM_DEBUG);
    dbg_nxt[`CDM_DBG_COUNTDM]   = countdm_r;
    dbg_nxt[`CDM_DBG_DSTORE]    = f_dstore_r;
    dbg_nxt[`CDM_DBG_DLOAD]     = f_dload_r;
    dbg_nxt[`CDM_DBG_STEP_EN]   = step_en_r;
    dbg_nxt[`CDM_DBG_IBRK]      = f_ibrk_r;
    dbg_nxt[`CDM_DBG_SWBP]      = f_swbp_r;
    dbg_nxt[`CDM_DBG_SSTEP]     = f_sstep_r;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dcs_rdata_r <= 32'h0000_0000;
      dbg_rdata_r <= 32'h0000_0000;
    end else begin
      dcs_rdata_r <= dcs_nxt;
      dbg_rdata_r <= dbg_nxt;
    end
  end

  // ===========================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_exc_in_normal;
    !in_debug_r && (sw_bp_exec || host_break_request || fetch_bus.hit || data_bus.hit);
  endsequence

  sequence s_entered;
    in_debug_r && fetch_redirect_r && (fetch_redirect_pc_r == 24'hF00200);
  endsequence

  AST_ENTRY: assert property (s_exc_in_normal |=> s_entered)
    else $error("debug entry or redirect missing");

  AST_ROUTE: assert property (fetch_valid && fetch_addr >= 24'hF00000
                              |=> fetch_to_probe_r)
    else $error("segment fetch not routed to probe");

  AST_NO_ROUTE: assert property (data_valid && data_addr < 24'hF00000
                                 |=> !data_to_probe_r)
    else $error("normal data routed to probe");

  AST_STAY: assert property (in_debug_r && !dbg_return_exec |=> in_debug_r)
    else $error("left debug mode without return");

  AST_EXIT: assert property (in_debug_r && dbg_return_exec
                             |=> !in_debug_r ##1 (dbg_rdata_r & 32'h000C_0013) == 32'h0)
    else $error("exit did not clear flags");

  AST_IRQ_MASK: assert property (in_debug_r |=> !blk_irq_take_r && !nb_irq_take_r)
    else $error("interrupt taken in debug mode");

  AST_NO_REENTRY: assert property (in_debug_r ##1 in_debug_r |-> !fetch_redirect_r)
    else $error("debug exception taken in debug mode");

  AST_SWBP: assert property (!in_debug_r && sw_bp_exec |=> ##1 dbg_rdata_r[1])
    else $error("software breakpoint flag missing");

  AST_SSTEP: assert property (!in_debug_r && step_en_r && instr_retire
                              |=> in_debug_r ##1 dbg_rdata_r[0])
    else $error("single step exception missing");

  AST_DBP: assert property (!in_debug_r && data_bus.hit
                            |=> ##1 (dbg_rdata_r[19] || dbg_rdata_r[18]))
    else $error("data breakpoint flag missing");

  AST_IBP: assert property (!in_debug_r && fetch_bus.hit |=> ##1 dbg_rdata_r[4])
    else $error("instruction breakpoint flag missing");

  AST_PROBE: assert property (!in_debug_r && host_break_request
                              |=> probe_break_taken_r && in_debug_r)
    else $error("probe break not taken");

  // the probe cause has no register bit, so its flag is watched here
  AST_PROBE_FLAG: assert property (!in_debug_r && host_break_request |=> f_probe_r)
    else $error("probe break cause not recorded");

  // antecedent on the cycle itself: the read views still hold zero at the release edge
  AST_CONST: assert property (!rst |=> dcs_rdata_r[29] && dcs_rdata_r[17]
                              && dcs_rdata_r[16] && (dcs_rdata_r & 32'hDFFC_FFE2) == 32'h0)
    else $error("fixed status bits wrong");

  AST_MIRROR: assert property (!rst |=>
                               dcs_rdata_r[4] == $past(processor_status_word[5])
                               && dcs_rdata_r[3] == $past(processor_status_word[6])
                               && dcs_rdata_r[2] == $past(nb_irq_req)
                               && dcs_rdata_r[0] == $past(probe_enabled))
    else $error("status mirror bits wrong");

  AST_IN_DEBUG_FLAG: assert property (!rst |=> dbg_rdata_r[30] == $past(in_debug_r))
    else $error("debug mode bit wrong");
endmodule

`default_nettype wire

// *** src/cdm_pkg.sv ***
`include "cdm_cfg.svh"

package cdm_pkg;
  typedef logic [`CDM_AW-1:0] cdm_addr_t;
  typedef enum logic {CDM_NORMAL, CDM_DEBUG} cdm_mode_t;

  // true when an address falls inside the debug memory segment
  function automatic logic cdm_in_dseg(input cdm_addr_t a);
    return (a >= `CDM_DSEG_LO) && (a <= `CDM_DSEG_HI);
  endfunction
endpackage

// *** src/cdm_seg_route.sv ***
`timescale 1ns/1ps
`default_nettype none

// flags accesses to the debug memory segment so they go to the probe port
module cdm_seg_route (
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  rst,
  // access stream
  cdm_bus_if.router  bus,
  // routing decision
  output var  logic  to_probe_r
);
  import cdm_pkg::*;

  // ===========================================================================
  // registered so the top output comes straight from a flip-flop
  logic to_probe_nxt;
  assign to_probe_nxt = bus.valid && cdm_in_dseg(bus.addr);

  always_ff @(posedge sys_clk) begin
    if (rst) to_probe_r <= 1'b0;
    else     to_probe_r <= to_probe_nxt;
  end
endmodule

`default_nettype wire
